// ==== capture_consts.vh ====
// Constants for the input capture channel
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONTROL     4'h0
`define ADDR_BUFFER      4'h4
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define BIT_IDLE_STOP    13
`define BIT_TIME_BASE    7
`define BIT_CPI_HI       6
`define BIT_CPI_LO       5
`define BIT_OVERFLOW     4
`define BIT_NOT_EMPTY    3
`define BIT_MODE_HI      2
`define BIT_MODE_LO      0
// ----------------------------------------
// Reset values, modes, prescaler tops and buffer depth
// ----------------------------------------
`define CONTROL_RESET    16'h0000
`define MODE_OFF         3'h0
`define MODE_EVERY_EDGE  3'h1
`define MODE_FALLING     3'h2
`define MODE_RISING      3'h3
`define MODE_RISE_4      3'h4
`define MODE_RISE_16     3'h5
`define MODE_UNUSED      3'h6
`define MODE_WAKE_ONLY   3'h7
`define PRESCALE_4       4'h3
`define PRESCALE_16      4'hf
`define FIFO_DEPTH       4
`endif

// ==== capture_fifo.v ====
// Capture value buffer, oldest first
module capture_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  output wire [WIDTH-1:0] head_data,
  output wire             empty,
  output wire             full
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [1:0]       wr_r;
  reg [1:0]       rd_r;
  reg [2:0]       cnt_r;
  wire            do_push;
  wire            do_pop;
  assign empty     = (cnt_r == 3'h0);
  assign full      = (cnt_r == DEPTH[2:0]);
  assign do_push   = push && !full;
  assign do_pop    = pop && !empty;
  assign head_data = mem_r[rd_r];
  always @(posedge clk) begin
    if (do_push) begin
      mem_r[wr_r] <= push_data;
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      wr_r  <= 2'h0;
      rd_r  <= 2'h0;
      cnt_r <= 3'h0;
    end else begin
      if (do_push) begin
        wr_r <= wr_r + 2'h1;
      end
      if (do_pop) begin
        rd_r <= rd_r + 2'h1;
      end
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + 3'h1;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule

// ==== input_capture_channel.v ====
// Input capture channel with Avalon-MM register slave
`include "capture_consts.vh"

module input_capture_channel (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        capture_input_pin,
  input  wire [15:0] timer_two_count,
  input  wire [15:0] timer_three_count,
  input  wire        cpu_idle,
  input  wire        cpu_sleep,
  output reg         capture_irq,
  output reg         wake_request
);
  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg        idle_stop_enable_r;
  reg        time_base_select_r;
  reg [1:0]  captures_per_interrupt_r;
  reg [2:0]  capture_mode_select_r;
  reg        buffer_overflow_flag_r;
  reg        ack_r;
  wire       buffer_not_empty_flag;
  wire       fifo_empty;
  wire       fifo_full;
  wire [15:0] fifo_head;
  wire       bus_req;
  wire       wr_ctrl;
  wire       rd_buf;
  wire [15:0] ctrl_view;

  assign bus_req = (avs_read || avs_write) && !ack_r;
  assign wr_ctrl = bus_req && avs_write && (avs_address == `ADDR_CONTROL);
  assign rd_buf  = bus_req && avs_read && (avs_address == `ADDR_BUFFER);
  assign buffer_not_empty_flag = !fifo_empty;
  assign ctrl_view = {2'h0, idle_stop_enable_r, 5'h00,
                      time_base_select_r, captures_per_interrupt_r,
                      buffer_overflow_flag_r, buffer_not_empty_flag,
                      capture_mode_select_r};

  // ----------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------
  reg        pin_meta_r;
  reg        pin_sync_r;
  reg        pin_prev_r;
  wire       rise;
  wire       fall;
  always @(posedge clk) begin
    if (!reset_n) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= capture_input_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end
  assign rise = pin_sync_r && !pin_prev_r;
  assign fall = !pin_sync_r && pin_prev_r;

  // ----------------------------------------
  // Event selection
  // ----------------------------------------
  reg        halted;
  reg        capture_event;
  reg [3:0]  prescale_r;
  reg [3:0]  prescale_nxt;
  reg [3:0]  prescale_top;
  reg        use_prescale;
  always @* begin
    halted        = idle_stop_enable_r && cpu_idle;
    capture_event = 1'b0;
    use_prescale  = 1'b0;
    prescale_top  = 4'h0;
    case (capture_mode_select_r)
      `MODE_EVERY_EDGE: begin
        capture_event = rise || fall;
      end
      `MODE_FALLING: begin
        capture_event = fall;
      end
      `MODE_RISING: begin
        capture_event = rise;
      end
      `MODE_RISE_4: begin
        use_prescale = 1'b1;
        prescale_top = `PRESCALE_4;
      end
      `MODE_RISE_16: begin
        use_prescale = 1'b1;
        prescale_top = `PRESCALE_16;
      end
      `MODE_OFF: begin
        capture_event = 1'b0;
      end
      `MODE_UNUSED: begin
        capture_event = 1'b0;
      end
      `MODE_WAKE_ONLY: begin
        capture_event = 1'b0;
      end
      default:         capture_event = 1'b0;
    endcase
    if (use_prescale && rise && (prescale_r == prescale_top)) begin
      capture_event = 1'b1;
    end
    if (halted) begin
      capture_event = 1'b0;
    end
    prescale_nxt = prescale_r;
    if (!use_prescale) begin
      prescale_nxt = 4'h0;
    end else if (rise && !halted) begin
      if (prescale_r == prescale_top) begin
        prescale_nxt = 4'h0;
      end else begin
        prescale_nxt = prescale_r + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Buffer
  // ----------------------------------------
  wire [15:0] sample;
  assign sample = time_base_select_r ? timer_two_count : timer_three_count;
  capture_fifo #(
    .WIDTH (16),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .push      (capture_event),
    .push_data (sample),
    .pop       (rd_buf),
    .head_data (fifo_head),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // ----------------------------------------
  // Interrupt counting
  // ----------------------------------------
  reg [1:0]  irq_cnt_r;
  reg        irq_nxt;
  reg        wake_nxt;
  always @* begin
    irq_nxt  = 1'b0;
    wake_nxt = 1'b0;
    if (capture_mode_select_r == `MODE_WAKE_ONLY) begin
      irq_nxt  = rise && (cpu_idle || cpu_sleep);
      wake_nxt = irq_nxt;
    end else if (capture_event) begin
      if (capture_mode_select_r == `MODE_EVERY_EDGE) begin
        irq_nxt = 1'b1;
      end else begin
        irq_nxt = (irq_cnt_r == captures_per_interrupt_r);
      end
      wake_nxt = cpu_idle || cpu_sleep;
    end
  end

  // ----------------------------------------
  // Control register write
  // ----------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      idle_stop_enable_r       <= 1'b0;
      time_base_select_r       <= 1'b0;
      captures_per_interrupt_r <= 2'h0;
      capture_mode_select_r    <= `MODE_OFF;
    end else if (wr_ctrl) begin
      idle_stop_enable_r       <= avs_writedata[`BIT_IDLE_STOP];
      time_base_select_r       <= avs_writedata[`BIT_TIME_BASE];
      captures_per_interrupt_r <=
        avs_writedata[`BIT_CPI_HI:`BIT_CPI_LO];
      capture_mode_select_r    <=
        avs_writedata[`BIT_MODE_HI:`BIT_MODE_LO];
    end
  end

  // ----------------------------------------
  // Prescaler and interrupt counter
  // ----------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      prescale_r <= 4'h0;
      irq_cnt_r  <= 2'h0;
    end else begin
      prescale_r <= prescale_nxt;
      if (wr_ctrl) begin
        irq_cnt_r <= 2'h0;
      end else if (capture_mode_select_r == `MODE_EVERY_EDGE ||
                   capture_mode_select_r == `MODE_WAKE_ONLY) begin
        irq_cnt_r <= 2'h0;
      end else if (capture_event) begin
        if (irq_cnt_r == captures_per_interrupt_r) begin
          irq_cnt_r <= 2'h0;
        end else begin
          irq_cnt_r <= irq_cnt_r + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Overflow flag
  // ----------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      buffer_overflow_flag_r <= 1'b0;
    end else begin
      // Set wins over clear when buffer drains
      if (capture_event && fifo_full) begin
        buffer_overflow_flag_r <= 1'b1;
      end else if (fifo_empty) begin
        buffer_overflow_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt and wake outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      capture_irq  <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      capture_irq  <= irq_nxt;
      wake_request <= wake_nxt;
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r           <= bus_req;
      avs_waitrequest <= !bus_req;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (bus_req && avs_read) begin
      case (avs_address)
        `ADDR_CONTROL: begin
          avs_readdata <= {16'h0000, ctrl_view};
        end
        `ADDR_BUFFER: begin
          avs_readdata <= {16'h0000, fifo_head};
        end
        default: begin
          avs_readdata <= 32'h00000000;
        end
      endcase
    end else begin
      avs_readdata <= 32'h00000000;
    end
  end
endmodule

// ==== input_capture_channel_properties.sv ====
// Port checker for the input capture channel
module input_capture_channel_properties (
  input wire        clk,
  input wire        reset_n,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        capture_input_pin,
  input wire        cpu_idle,
  input wire        cpu_sleep,
  input wire        capture_irq,
  input wire        wake_request
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_answer_next: assert property ($rose(avs_read || avs_write)
    |=> !avs_waitrequest) else $error("late answer");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held");
  a_data_idle: assert property (avs_waitrequest |-> avs_readdata == 0)
    else $error("data outside answer");
  a_ctl_unused: assert property (!avs_waitrequest && avs_read &&
    avs_address == 4'h0 |-> (avs_readdata & 32'hffffdf00) == 0)
    else $error("unused bits set");
  a_unmapped_zero: assert property (!avs_waitrequest && avs_read &&
    avs_address != 4'h0 && avs_address != 4'h4 |-> avs_readdata == 0)
    else $error("unmapped data");
  a_irq_pulse: assert property (capture_irq |=> !capture_irq)
    else $error("irq held");
  a_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake held");
  a_wake_power: assert property (wake_request |->
    $past(cpu_idle || cpu_sleep)) else $error("wake while running");
  a_quiet_pin: assert property ($stable(capture_input_pin)[*8]
    |-> !capture_irq && !wake_request) else $error("event without edge");
endmodule
bind input_capture_channel input_capture_channel_properties chk (
  .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .capture_input_pin(capture_input_pin),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .capture_irq(capture_irq),
  .wake_request(wake_request));

// ==== capture_pin_source.sv ====
// Model of the signal source driving the capture pin
module capture_pin_source (
  input  wire        clk,
  input  wire        start,
  input  wire [7:0]  toggles,
  output logic       pin,
  output logic       busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h0;
  logic [2:0] gap = 3'h0;
  initial pin = 1'b0;
  initial busy = 1'b0;
  // ----
  // Each level held eight cycles
  // ----
  always @(posedge clk) begin
    if (start && !busy) begin
      left <= toggles;
      busy <= toggles != 8'h0;
      gap <= 3'h0;
    end else if (busy) begin
      gap <= gap + 3'h1;
      if (gap == 3'h7) begin
        pin <= ~pin;
        left <= left - 8'h1;
        busy <= left != 8'h1;
      end
    end
  end
endmodule

// ==== input_capture_channel_tb.sv ====
// Self-checking bench for the input capture channel
module input_capture_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] c; int t; logic [1:0] p;
                  int n; int i; int w; logic [15:0] v;} row_t;
  logic        clk = 0, reset_n = 0, avs_read = 0, avs_write = 0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, capture_irq, wake_request, pin, busy;
  logic        cpu_idle = 0, cpu_sleep = 0, start = 0, pin_d = 0;
  logic [7:0]  toggles = 8'h0;
  logic [15:0] rises = 16'h0;
  int          error_cnt = 0, samples_checked = 0, irqs = 0, wakes = 0, k;
  row_t rows[12] = '{
    '{16'h0000, 8, 0, 0, 0, 0, 0}, '{16'h0006, 8, 0, 0, 0, 0, 0},
    '{16'h00e3, 8, 0, 4, 1, 0, 0}, '{16'h0042, 6, 0, 3, 1, 0, 16'h3b3b},
    '{16'h0061, 4, 0, 4, 4, 0, 16'h3b3b},
    '{16'h0024, 16, 0, 2, 1, 0, 16'h3b3b},
    '{16'h0005, 32, 0, 1, 1, 0, 16'h3b3b}, '{16'h0007, 4, 0, 0, 0, 0, 0},
    '{16'h0007, 4, 1, 0, 2, 2, 0}, '{16'h0007, 4, 2, 0, 2, 2, 0},
    '{16'h2003, 4, 1, 0, 0, 0, 0}, '{16'h0003, 4, 2, 2, 2, 2, 16'h3b3b}};
  // ----
  // Clock, pin source and design
  // ----
  always #4 clk = ~clk;
  always @(posedge clk) begin
    pin_d <= pin;
    if (pin && !pin_d) rises <= rises + 16'h1;
    if (capture_irq === 1'b1) irqs++;
    if (wake_request === 1'b1) wakes++;
  end
  capture_pin_source src (.clk(clk), .start(start), .toggles(toggles),
    .pin(pin), .busy(busy));
  input_capture_channel dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_input_pin(pin),
    .timer_two_count(16'h2a00 + rises), .timer_three_count(16'h3b3b),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .capture_irq(capture_irq), .wake_request(wake_request));
  // ----
  // Tasks
  // ----
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin @(posedge clk); n++; end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin error_cnt++; wrap_up; end
  endtask
  task automatic edges(int t);
    int n;
    n = 0;
    toggles <= t[7:0];
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 400) begin @(posedge clk); n++; end
    if (n >= 400) begin error_cnt++; wrap_up; end
    repeat (10) @(posedge clk);
  endtask
  task automatic drain(logic [15:0] v);
    k = 0;
    bus(0, 4'h0, 0);
    while (q[3] === 1'b1 && k < 6) begin
      bus(0, 4'h4, 0);
      if (v != 16'h0) chk("capture", q, {16'h0, v});
      k++;
      bus(0, 4'h0, 0);
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(0, 4'h0, 0);
    chk("ctl_reset", q, 32'h0);
    foreach (rows[r]) begin
      bus(1, 4'h0, {16'h0, rows[r].c});
      {cpu_sleep, cpu_idle} <= rows[r].p;
      irqs = 0;
      wakes = 0;
      edges(rows[r].t);
      chk("irqs", irqs, rows[r].i);
      chk("wakes", wakes, rows[r].w);
      {cpu_sleep, cpu_idle} <= 2'b00;
      drain(rows[r].v);
      chk("captures", k, rows[r].n);
    end
    rises <= 16'h0;
    bus(1, 4'h0, 32'h0083);
    edges(10);
    bus(0, 4'h0, 0);
    chk("ctl_full", q, 32'h009b);
    bus(1, 4'h0, 32'hff1b);
    bus(0, 4'h0, 0);
    chk("ctl_ro", q, 32'h201b);
    for (int i = 1; i < 5; i++) begin
      bus(0, 4'h4, 0);
      chk("oldest", q, 32'h2a00 + i);
    end
    bus(1, 4'h4, 32'h1234);
    bus(0, 4'h0, 0);
    chk("ctl_empty", q, 32'h2003);
    bus(0, 4'h8, 0);
    chk("unmapped", q, 32'h0);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(0, 4'h0, 0);
    chk("ctl_rst2", q, 32'h0);
    wrap_up;
  end
endmodule
